/* core/ms_tick_gen.sv */
// Free-running millisecond tick prescaler
`timescale 1ns/1ps
module ms_tick_gen
   #(parameter int TICK_CYCLES = pd_seq_pkg::TICK_CYCLES)
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   output logic      tick_o
);
   logic [pd_seq_pkg::TICK_W-1:0] count;
   logic [pd_seq_pkg::TICK_W-1:0] next_count;
   logic                          next_tick;

   always_comb
   begin
      next_count = count + 16'h0001;
      next_tick  = 1'b0;
      if (count == pd_seq_pkg::TICK_W'(TICK_CYCLES - 1))
      begin
         next_count = 16'h0000;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         count  <= 16'h0000;
         tick_o <= 1'b0;
      end
      else
      begin
         count  <= next_count;
         tick_o <= next_tick;
      end
   end
endmodule

/* core/pd_seq_pkg.sv */
// Constants for the attach and fault sequencer
package pd_seq_pkg;
   // ----------------------------------------------------------------
   // Clock and tick
   // ----------------------------------------------------------------
   localparam int CLK_HZ        = 40000000;
   localparam int TICK_US       = 1000;
   localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
   localparam int TICK_W        = 16;
   localparam int MS_W          = 13;
   // ----------------------------------------------------------------
   // Intervals in milliseconds (T_NORESP_S in seconds), as typical values
   // ----------------------------------------------------------------
   localparam int T_ATTACH_MS   = 185;
   localparam int T_SELECT_MS   = 30;
   localparam int T_FAULT_MS    = 1395;
   localparam int T_SHORT_MS    = 985;
   localparam int T_ON_MS       = 600;
   localparam real T_NORESP_S   = 4.8;
   localparam int T_NORESP_MS   = 4800;
   localparam int T_LOGIC_MS    = 5;
   localparam int T_PROT_MS     = 190;
   localparam int T_SETTLE_MS   = 260;
   localparam int T_HR_OFF_MS   = 30;
   localparam int T_RECOVER_MS  = 765;
   // Limits for fast paths, in microseconds except T_VCONN_MS in milliseconds and FAST_CYCLES in clock cycles
   localparam int T_GDOFF_US    = 5;
   localparam int T_FOVP_US     = 30;
   localparam int T_OCP_US      = 30;
   localparam int T_VBUS_DISCHARGE_PIN_US     = 10;
   localparam int T_VCONN_MS    = 2;
   localparam int FAST_CYCLES   = T_GDOFF_US * (CLK_HZ / 1000000);
   localparam logic [MS_W-1:0] MS_ZERO = 13'h0000;
endpackage

/* core/pd_source_attach_fault_sequencer.sv */
// Source port attach, supply select and fault sequencer
`timescale 1ns/1ps
module pd_source_attach_fault_sequencer
   #(parameter int TICK_CYCLES = pd_seq_pkg::TICK_CYCLES)
(
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       sink_present_i,
   input  wire logic       power_good_in_n_i,
   input  wire logic       vin_present_i,
   input  wire logic       vbus_short_i,
   input  wire logic       fast_ovp_i,
   input  wire logic       ocp_large_i,
   input  wire logic       temp1_trip_i,
   input  wire logic       sink_active_i,
   input  wire logic       request_accept_i,
   input  wire logic [1:0] request_select_i,
   output logic            attach_indicator_n_o,
   output logic            logic_supply_out_o,
   output logic            vconn_enable_o,
   output logic            n_channel_switch_gate_drive_o,
   output logic            supply_select_a_o,
   output logic            supply_select_b_o,
   output logic            vbus_discharge_pin_o,
   output logic            hard_reset_o,
   output logic            ps_ready_o,
   output logic            slow_overvoltage_check_o,
   output logic            slow_undervoltage_check_o,
   output logic            uv_ocp_enable_o
);
   // ----------------------------------------------------------------
   // Input synchronisers and the shared tick
   // ----------------------------------------------------------------
   logic [10:0] pins_s;
   logic        tick;

   sync2 #(.W(11)) u_sync
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     ({sink_present_i, power_good_in_n_i, vin_present_i,
                 vbus_short_i, fast_ovp_i, ocp_large_i, temp1_trip_i,
                 sink_active_i, request_accept_i, request_select_i}),
      .q_o     (pins_s)
   );

   ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_o  (tick)
   );

   logic sink_s, pg_n_s, vin_s, short_s, ovp_s, ocp_s, temp_s;
   logic active_s, accept_s;
   logic [1:0] sel_s;
   assign sink_s   = pins_s[10];
   assign pg_n_s   = pins_s[9];
   assign vin_s    = pins_s[8];
   assign short_s  = pins_s[7];
   assign ovp_s    = pins_s[6];
   assign ocp_s    = pins_s[5];
   assign temp_s   = pins_s[4];
   assign active_s = pins_s[3];
   assign accept_s = pins_s[2];
   // Select rides the same flops as accept so both land together
   assign sel_s    = pins_s[1:0];

   logic supply_fault;
   assign supply_fault = pg_n_s | ~vin_s;

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_DEBOUNCE, ST_POWERED, ST_WAIT_SEL,
                 ST_SETTLE, ST_HR_OFF, ST_RECOVER} state_t;

   state_t            state, next_state;
   logic [12:0]       ms, next_ms;        // ms in current state
   logic [12:0]       retry, next_retry;  // ms toward next hard reset
   logic [12:0]       prot, next_prot;    // ms since switch turned on
   logic [1:0]        sel, next_sel;
   logic [1:0]        pend, next_pend;
   logic              attached, next_attached;
   logic              first_hr, next_first_hr;
   logic              hr, next_hr;
   logic              rdy, next_rdy;
   logic              gate_seq;
   logic              vbus_discharge_pin;
   logic [12:0]       retry_lim;

   // Supply fault interval wins over short, short over no-response
   always_comb
   begin
      retry_lim = 13'(pd_seq_pkg::T_NORESP_MS);
      if (supply_fault)
      begin
         if (first_hr)
            retry_lim = 13'(pd_seq_pkg::T_ON_MS);
         else
            retry_lim = 13'(pd_seq_pkg::T_FAULT_MS);
      end
      else if (short_s)
         retry_lim = 13'(pd_seq_pkg::T_SHORT_MS);
   end

   always_comb
   begin
      next_state    = state;
      next_ms       = (tick && ms != 13'h1fff) ? ms + 13'h0001 : ms;
      next_retry    = tick ? retry + 13'h0001 : retry;
      next_prot     = (tick && prot != 13'h1fff) ? prot + 13'h0001 : prot;
      next_sel      = sel;
      next_pend     = pend;
      next_attached = attached;
      next_first_hr = first_hr;
      next_hr       = 1'b0;
      next_rdy      = 1'b0;
      if (active_s)
         next_retry = pd_seq_pkg::MS_ZERO;
      case (state)
         ST_IDLE:
         begin
            next_sel = 2'h0;
            if (sink_s)
            begin
               next_state = ST_DEBOUNCE;
               next_ms    = pd_seq_pkg::MS_ZERO;
            end
         end
         ST_DEBOUNCE:
         begin
            if (!sink_s)
               next_state = ST_IDLE;
            else if (ms >= 13'(pd_seq_pkg::T_ATTACH_MS))
            begin
               next_state    = ST_POWERED;
               next_attached = 1'b1;
               next_first_hr = 1'b1;
               next_retry    = pd_seq_pkg::MS_ZERO;
               next_prot     = pd_seq_pkg::MS_ZERO;
            end
         end
         ST_POWERED, ST_WAIT_SEL, ST_SETTLE:
         begin
            if (retry >= retry_lim)
            begin
               next_hr       = 1'b1;
               next_first_hr = 1'b0;
               // Fault retries count from one transmission to the next
               next_retry    = pd_seq_pkg::MS_ZERO;
               next_state    = ST_HR_OFF;
               next_ms       = pd_seq_pkg::MS_ZERO;
            end
            else if (state == ST_POWERED && accept_s)
            begin
               next_pend  = sel_s;
               next_state = ST_WAIT_SEL;
               next_ms    = pd_seq_pkg::MS_ZERO;
            end
            else if (state == ST_WAIT_SEL
                     && ms >= 13'(pd_seq_pkg::T_SELECT_MS))
            begin
               next_sel   = pend;
               next_state = ST_SETTLE;
               next_ms    = pd_seq_pkg::MS_ZERO;
            end
            else if (state == ST_SETTLE
                     && ms >= 13'(pd_seq_pkg::T_SETTLE_MS))
            begin
               next_rdy   = 1'b1;
               next_state = ST_POWERED;
            end
         end
         ST_HR_OFF:
            if (ms >= 13'(pd_seq_pkg::T_HR_OFF_MS))
            begin
               next_state = ST_RECOVER;
               next_ms    = pd_seq_pkg::MS_ZERO;
               next_sel   = 2'h0;
            end
         ST_RECOVER:
            if (ms >= 13'(pd_seq_pkg::T_RECOVER_MS))
            begin
               next_state = ST_POWERED;
               next_prot  = pd_seq_pkg::MS_ZERO;
               // A silent sink gets its full interval with the gate on
               if (!supply_fault && !short_s)
                  next_retry = pd_seq_pkg::MS_ZERO;
            end
         default:
            next_state = ST_IDLE;
      endcase
      if (!sink_s && state != ST_IDLE && state != ST_DEBOUNCE)
      begin
         next_state    = ST_IDLE;
         next_attached = 1'b0;
         next_hr       = 1'b0;
         next_sel      = 2'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state    <= ST_IDLE;
         ms       <= 13'h0000;
         retry    <= 13'h0000;
         prot     <= 13'h0000;
         sel      <= 2'h0;
         pend     <= 2'h0;
         attached <= 1'b0;
         first_hr <= 1'b0;
         hr       <= 1'b0;
         rdy      <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         ms       <= next_ms;
         retry    <= next_retry;
         prot     <= next_prot;
         sel      <= next_sel;
         pend     <= next_pend;
         attached <= next_attached;
         first_hr <= next_first_hr;
         hr       <= next_hr;
         rdy      <= next_rdy;
      end
   end

   // ----------------------------------------------------------------
   // Outputs; fast shutdown paths bypass the millisecond timing
   // ----------------------------------------------------------------
   assign gate_seq = attached && state != ST_RECOVER
                     && !(state == ST_HR_OFF
                          && ms >= 13'(pd_seq_pkg::T_HR_OFF_MS));
   assign vbus_discharge_pin     = state == ST_RECOVER || (sink_s == 1'b0 && attached);

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         attach_indicator_n_o      <= 1'b1;
         logic_supply_out_o        <= 1'b0;
         vconn_enable_o            <= 1'b0;
         n_channel_switch_gate_drive_o         <= 1'b0;
         supply_select_a_o         <= 1'b0;
         supply_select_b_o         <= 1'b0;
         vbus_discharge_pin_o      <= 1'b0;
         hard_reset_o              <= 1'b0;
         ps_ready_o                <= 1'b0;
         slow_overvoltage_check_o  <= 1'b0;
         slow_undervoltage_check_o <= 1'b0;
         uv_ocp_enable_o           <= 1'b0;
      end
      else
      begin
         attach_indicator_n_o <= ~attached;
         logic_supply_out_o   <= sink_s;
         vconn_enable_o       <= attached;
         // Asynchronous faults cut the drive in a few cycles
         n_channel_switch_gate_drive_o    <= gate_seq && !pg_n_s && !ovp_s
                                 && !ocp_s;
         supply_select_a_o    <= sel[0];
         supply_select_b_o    <= sel[1];
         vbus_discharge_pin_o <= vbus_discharge_pin && !temp_s;
         hard_reset_o         <= hr;
         ps_ready_o           <= rdy;
         // Masked while the bus voltage is moving
         slow_overvoltage_check_o  <= state == ST_POWERED;
         slow_undervoltage_check_o <= state == ST_POWERED;
         uv_ocp_enable_o      <= gate_seq
                                 && prot >= 13'(pd_seq_pkg::T_PROT_MS);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_GATE_PG: assert property (@(posedge clk_i)
      disable iff (reset_i)
      $rose(power_good_in_n_i) |-> ##3 !n_channel_switch_gate_drive_o)
      else $error("gate drive on after power good lost");
   AST_GATE_OFF_PG: assert property (@(posedge clk_i)
      disable iff (reset_i) power_good_in_n_i [*3] |=> !n_channel_switch_gate_drive_o)
      else $error("gate drive stayed on with power good low");
   AST_GATE_OFF_OVP: assert property (@(posedge clk_i)
      disable iff (reset_i) fast_ovp_i [*3] |=> !n_channel_switch_gate_drive_o)
      else $error("gate drive stayed on at over-voltage");
   AST_GATE_OFF_OCP: assert property (@(posedge clk_i)
      disable iff (reset_i) ocp_large_i [*3] |=> !n_channel_switch_gate_drive_o)
      else $error("gate drive stayed on at over-current");
   AST_VBUS_DISCHARGE_PIN_TEMP: assert property (@(posedge clk_i)
      disable iff (reset_i) temp1_trip_i [*3] |=> !vbus_discharge_pin_o)
      else $error("discharge on while hot");
   AST_VCONN_ATTACH: assert property (@(posedge clk_i)
      disable iff (reset_i) $fell(attach_indicator_n_o) |-> vconn_enable_o)
      else $error("vconn not with attach");
   AST_RDY_SEL: assert property (@(posedge clk_i)
      disable iff (reset_i) ps_ready_o |-> $past(state, 2) == ST_SETTLE)
      else $error("power ready outside settle");
   AST_HR_ATT: assert property (@(posedge clk_i)
      disable iff (reset_i) hard_reset_o |-> !attach_indicator_n_o)
      else $error("hard reset without attach");
   AST_MASK: assert property (@(posedge clk_i)
      disable iff (reset_i)
      $changed(supply_select_a_o) |-> !slow_overvoltage_check_o)
      else $error("slow checks live during transition");
   COV_ATTACH: cover property (@(posedge clk_i) $fell(attach_indicator_n_o));
   COV_HR: cover property (@(posedge clk_i) hard_reset_o);
   COV_RDY: cover property (@(posedge clk_i) ps_ready_o);
endmodule

/* core/sync2.sv */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sync2 #(parameter int W = 1)
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

/* tb/pd_source_attach_fault_sequencer_tb_top.sv */
// Self-checking bench for the attach and fault sequencer
`timescale 1ns/1ps
module pd_source_attach_fault_sequencer_tb_top;
   // Shortened tick keeps the run short; every millisecond is MS cycles
   localparam int MS = 20;
   // Slack covers sync flops and output registers; the extra MS in each bound covers one tick of phase
   localparam int SL = 12;

   logic clk_i, reset_i, attach, request, pg_n, vin, shrt, ovp, ocp, temp;
   logic [1:0] sel;
   logic sink_present, sink_active, accept;
   logic [1:0] req_sel;
   logic attach_n, logic_sup, vconn, gate, sel_a, sel_b, vbus_discharge_pin, hard_rst;
   logic ps_rdy, sovp, suvp, uv_ocp;
   longint cyc, t0, ta, ts;
   int bad_count, cmp_count, n;

   sink_model sink_u
   (
      .clk_i            (clk_i),
      .attach_i         (attach),
      .request_i        (request),
      .sel_i            (sel),
      .sink_present_o   (sink_present),
      .sink_active_o    (sink_active),
      .request_accept_o (accept),
      .request_select_o (req_sel)
   );

   pd_source_attach_fault_sequencer #(.TICK_CYCLES(MS)) dut_u
   (
      .clk_i                     (clk_i),
      .reset_i                   (reset_i),
      .sink_present_i            (sink_present),
      .power_good_in_n_i         (pg_n),
      .vin_present_i             (vin),
      .vbus_short_i              (shrt),
      .fast_ovp_i                (ovp),
      .ocp_large_i               (ocp),
      .temp1_trip_i              (temp),
      .sink_active_i             (sink_active),
      .request_accept_i          (accept),
      .request_select_i          (req_sel),
      .attach_indicator_n_o      (attach_n),
      .logic_supply_out_o        (logic_sup),
      .vconn_enable_o            (vconn),
      .n_channel_switch_gate_drive_o         (gate),
      .supply_select_a_o         (sel_a),
      .supply_select_b_o         (sel_b),
      .vbus_discharge_pin_o      (vbus_discharge_pin),
      .hard_reset_o              (hard_rst),
      .ps_ready_o                (ps_rdy),
      .slow_overvoltage_check_o  (sovp),
      .slow_undervoltage_check_o (suvp),
      .uv_ocp_enable_o           (uv_ocp)
   );

   // ----------------------------------------------------------------
   // Clock, cycle count and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
   end

   // Whole run is about 2200 ms of attach, transition and retry timing
   initial
   begin
      repeat (2400 * MS) @(posedge clk_i);
      $display("FAIL watchdog expected done seen hung");
      bad_count++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // Shared checking tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("FAIL %s expected %b seen %b", nm, exp, got);
         bad_count++;
      end
   endtask

   task automatic chk_span(input string nm, input longint lo,
                           input longint hi, input longint got);
      cmp_count++;
      if (got < lo || got > hi)
      begin
         $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, got);
         bad_count++;
      end
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: sig = attach_n;
         1: sig = logic_sup;
         2: sig = vconn;
         3: sig = gate;
         4: sig = sel_a;
         5: sig = ps_rdy;
         6: sig = uv_ocp;
         7: sig = hard_rst;
         default: sig = vbus_discharge_pin;
      endcase
   endfunction

   // Poll one cycle at a time; a one-cycle pulse cannot slip past
   task automatic wait_sig(input int k, input logic v, input int lim);
      n = 0;
      while (sig(k) !== v && n <= lim)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk($sformatf("wait on output %0d", k), v, sig(k));
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      chk("attach_indicator_n", 1'b1, attach_n);
      chk("gate_drive", 1'b0, gate);
      chk("vconn_enable", 1'b0, vconn);
      chk("hard_reset", 1'b0, hard_rst);
   endtask

   task automatic test_attach();
      @(posedge clk_i);
      attach <= 1'b1;
      t0 = cyc;
      #1;
      wait_sig(1, 1'b1, 5 * MS);
      chk_span("logic_supply delay", 0, 5 * MS, cyc - t0);
      chk("attach_indicator_n early", 1'b1, attach_n);
      wait_sig(0, 1'b0, 187 * MS);
      ta = cyc;
      chk_span("attach debounce", 184 * MS, 186 * MS + SL, ta - t0);
      wait_sig(2, 1'b1, 2 * MS);
      chk_span("vconn delay", 0, 2 * MS, cyc - ta);
      wait_sig(3, 1'b1, 2 * MS);
      chk_span("gate_drive delay", 0, 2 * MS, cyc - ta);
   endtask

   task automatic test_request();
      @(posedge clk_i);
      request <= 1'b1;
      @(posedge clk_i);
      request <= 1'b0;
      t0 = cyc;
      #1;
      chk("supply_select_a held", 1'b0, sel_a);
      wait_sig(4, 1'b1, 32 * MS);
      ts = cyc;
      chk_span("select delay", 29 * MS, 31 * MS + SL, ts - t0);
      chk("supply_select_b", 1'b0, sel_b);
      chk("slow_ov masked", 1'b0, sovp);
      chk("slow_uv masked", 1'b0, suvp);
      wait_sig(6, 1'b1, 192 * MS);
      chk_span("uv_ocp delay", 189 * MS, 191 * MS + SL, cyc - ta);
      wait_sig(5, 1'b1, 262 * MS);
      chk_span("ps_ready delay", 259 * MS, 261 * MS + SL, cyc - ts);
      @(posedge clk_i);
      #1;
      chk("ps_ready pulse", 1'b0, ps_rdy);
      chk("hard_reset quiet", 1'b0, hard_rst);
   endtask

   task automatic test_power_fail();
      @(posedge clk_i);
      pg_n <= 1'b1;
      t0 = cyc;
      #1;
      wait_sig(3, 1'b0, 200);
      chk_span("gate_drive off", 0, 200, cyc - t0);
   endtask

   // Over-voltage and over-current each cut the gate, which then returns
   task automatic test_fast_off();
      @(posedge clk_i);
      ovp <= 1'b1;
      t0 = cyc;
      #1;
      wait_sig(3, 1'b0, 1200);
      chk_span("gate_drive off ovp", 0, 1200, cyc - t0);
      @(posedge clk_i);
      ovp <= 1'b0;
      #1;
      wait_sig(3, 1'b1, 20);
      @(posedge clk_i);
      ocp <= 1'b1;
      t0 = cyc;
      #1;
      wait_sig(3, 1'b0, 1200);
      chk_span("gate_drive off ocp", 0, 1200, cyc - t0);
      @(posedge clk_i);
      ocp <= 1'b0;
      #1;
      wait_sig(3, 1'b1, 20);
   endtask

   // Supply fault stays on: retries, recovery discharge, hot cut-off
   task automatic test_fault();
      longint h, r;
      wait_sig(7, 1'b1, 620 * MS);
      h = cyc;
      wait_sig(8, 1'b1, 32 * MS);
      r = cyc;
      chk_span("recover start", 29 * MS, 31 * MS + SL, r - h);
      @(posedge clk_i);
      temp <= 1'b1;
      t0 = cyc;
      #1;
      wait_sig(8, 1'b0, 400);
      chk_span("discharge off hot", 0, 400, cyc - t0);
      @(posedge clk_i);
      temp <= 1'b0;
      #1;
      wait_sig(8, 1'b1, 20);
      wait_sig(8, 1'b0, 767 * MS);
      chk_span("recover hold", 764 * MS, 766 * MS + SL, cyc - r);
      wait_sig(7, 1'b1, 1397 * MS);
      chk_span("fault retry", 1394 * MS, 1396 * MS + SL, cyc - h);
   endtask

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      cyc = 0;
      bad_count = 0;
      cmp_count = 0;
      reset_i = 1'b1;
      attach = 1'b0;
      request = 1'b0;
      sel = 2'h1;
      pg_n = 1'b0;
      vin = 1'b1;
      shrt = 1'b0;
      ovp = 1'b0;
      ocp = 1'b0;
      temp = 1'b0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      #1;
      test_reset();
      test_attach();
      test_request();
      test_fast_off();
      test_power_fail();
      test_fault();
      complete_run();
   end
endmodule

/* tb/sink_model.sv */
// Behavioural Type-C sink on the far side of the source sequencer
`timescale 1ns/1ps
module sink_model
(
   input  wire logic       clk_i,
   input  wire logic       attach_i,
   input  wire logic       request_i,
   input  wire logic [1:0] sel_i,
   output logic            sink_present_o,
   output logic            sink_active_o,
   output logic            request_accept_o,
   output logic [1:0]      request_select_o
);
   initial
   begin
      sink_present_o   = 1'b0;
      sink_active_o    = 1'b0;
      request_accept_o = 1'b0;
      request_select_o = 2'h0;
   end

   // A request also counts as sink traffic; select held with the request
   always @(posedge clk_i)
   begin
      sink_present_o   <= attach_i;
      sink_active_o    <= request_i;
      request_accept_o <= request_i;
      request_select_o <= sel_i;
   end
endmodule
